/* verilog/alb_map.svh */
// Address map, field positions and reset values of the execution datapath
`ifndef ALB_MAP_SVH
`define ALB_MAP_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define ALB_ADDR_CTRL      12'h000
`define ALB_ADDR_STATUS    12'h004
`define ALB_ADDR_FILE_OP_ACCUMULATOR_BASE 12'h040
`define ALB_FILE_OP_ACCUMULATOR_MASK      12'hFC0
// ****************************************
// Field positions and reset values
// ****************************************
`define ALB_CTRL_EN_BIT    0
`define ALB_CTRL_EN_RST    1'b1
`define ALB_ST_C           0
`define ALB_ST_DC          1
`define ALB_ST_N           2
`define ALB_ST_OV          3
`define ALB_ST_Z           4
`define ALB_W0_IDX         4'h0
`endif

/* verilog/alb_pkg.sv */
// Types shared by the execution datapath
`default_nettype none
package alb_pkg;
    typedef enum logic [3:0] {
        ALB_OP_ADD, ALB_OP_SUM_WITH_CARRY_OP, ALB_OP_AND, ALB_OP_ASR1, ALB_OP_ASRW,
        ALB_OP_ASRK, ALB_OP_BIT_ZERO_OP, ALB_OP_BRA, ALB_OP_BRAW
    } alb_op_type;
    typedef enum logic [1:0] {
        ALB_FORM_FILE, ALB_FORM_WIDE_IMMEDIATE, ALB_FORM_REG3, ALB_FORM_SHORT_IMMEDIATE
    } alb_form_type;
    typedef enum logic [3:0] {
        ALB_CC_ALWAYS, ALB_CC_C, ALB_CC_NC, ALB_CC_Z, ALB_CC_NZ, ALB_CC_N, ALB_CC_NN,
        ALB_CC_OV, ALB_CC_NOV, ALB_CC_GE, ALB_CC_GT, ALB_CC_LE, ALB_CC_LT,
        ALB_CC_GTU, ALB_CC_LEU, ALB_CC_LTU
    } alb_cond_type;
    typedef enum logic {ALB_PH_EXEC, ALB_PH_FLUSH} alb_phase_type;
    typedef struct packed {
        logic c;
        logic dc;
        logic n;
        logic ov;
        logic z;
    } alb_flags_type;
    typedef struct packed {
        alb_op_type   op;
        alb_form_type form;
        alb_cond_type cond;
        logic         byte_mode;
        logic         dest_file;
        logic [12:0]  faddr;
        logic [15:0]  file_rdata;
        logic [3:0]   wb;
        logic [3:0]   ws;
        logic [3:0]   wd;
        logic [9:0]   wide_immediate;
        logic [4:0]   short_immediate;
        logic [3:0]   shift_immediate;
        logic [3:0]   bit_index_field;
        logic [15:0]  offset;
    } alb_instr_type;
    typedef struct packed {
        alb_phase_type   phase;
        logic [15:0][15:0] file_op_accumulator;
        alb_flags_type   flags;
        logic            enable;
        logic            ready;
        logic            nop_slot;
        logic            jump;
        logic            jump_abs;
        logic [15:0]     jump_val;
        logic            mem_wr;
        logic [12:0]     mem_addr;
        logic [15:0]     mem_data;
        logic            pready;
        logic [31:0]     prdata;
        logic            pslverr;
    } alb_state_type;
endpackage : alb_pkg
`default_nettype wire

/* verilog/alb_shift.sv */
// Arithmetic right barrel shifter, byte or word
`default_nettype none
module alb_shift (
    // Operand
    input  wire logic [15:0] value_i,
    input  wire logic [3:0]  amount_i,
    input  wire logic        byte_i,
    // Result
    output logic      [15:0] value_o
);
    logic [4:0][15:0] stage;
    logic             sign;

    // Byte operand is sign-extended so one shifter serves both widths
    assign sign     = byte_i ? value_i[7] : value_i[15];
    assign stage[0] = byte_i ? {{8{value_i[7]}}, value_i[7:0]} : value_i;

    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_stage
            localparam int SH = 1 << k;
            assign stage[k+1] = amount_i[k] ? {{SH{sign}}, stage[k][15:SH]} : stage[k];
        end
    endgenerate

    assign value_o = stage[4];
endmodule : alb_shift
`default_nettype wire

/* verilog/alb_core.sv */
// Execution datapath: add, and, arithmetic shift, bit clear, branches
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`default_nettype none
`include "alb_map.svh"
module alb_core import alb_pkg::*; (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          sys_rst_i,
    // Decoder side
    input  wire logic          instr_valid_i,
    input  wire alb_instr_type instr_i,
    output logic               instr_ready_o,
    output logic               nop_slot_o,
    // Program counter side
    output logic               jump_o,
    output logic               jump_abs_o,
    output logic [15:0]        jump_val_o,
    // Data memory side
    output logic               mem_wr_o,
    output logic [12:0]        mem_addr_o,
    output logic [15:0]        mem_data_o,
    output alb_flags_type      flags_o,
    // APB slave
    input  wire logic          psel_i,
    input  wire logic          penable_i,
    input  wire logic          pwrite_i,
    input  wire logic [11:0]   paddr_i,
    input  wire logic [31:0]   pwdata_i,
    output logic [31:0]        prdata_o,
    output logic               pready_o,
    output logic               pslverr_o
);
    alb_state_type s;
    alb_state_type next_s;
    logic          accept;
    logic          byte_m;
    logic          wr_reg;
    logic          wr_file;
    logic          taken;
    logic          carry_in;
    logic [3:0]    wr_idx;
    logic [3:0]    shift_amt;
    logic [3:0]    clr_idx;
    logic [15:0]   op_a;
    logic [15:0]   op_b;
    logic [15:0]   res;
    logic [15:0]   dst_old;
    logic [15:0]   merged;
    logic [15:0]   shift_res;
    logic [16:0]   sum;
    logic [4:0]    nib;
    logic          is_file_op_accumulator;
    logic          apb_wr;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] lo_byte(input logic [15:0] v, input logic b);
        return b ? {8'h00, v[7:0]} : v;
    endfunction : lo_byte

    function automatic logic msb(input logic [15:0] v, input logic b);
        return b ? v[7] : v[15];
    endfunction : msb

    function automatic logic is_zero(input logic [15:0] v, input logic b);
        return b ? (v[7:0] == 8'h00) : (v == 16'h0000);
    endfunction : is_zero

    function automatic logic cond_met(input alb_cond_type c, input alb_flags_type f);
        logic lt;
        lt = f.n ^ f.ov;
        unique case (c)
            ALB_CC_ALWAYS: return 1'b1;
            ALB_CC_C:      return f.c;
            ALB_CC_NC:     return !f.c;
            ALB_CC_Z:      return f.z;
            ALB_CC_NZ:     return !f.z;
            ALB_CC_N:      return f.n;
            ALB_CC_NN:     return !f.n;
            ALB_CC_OV:     return f.ov;
            ALB_CC_NOV:    return !f.ov;
            ALB_CC_GE:     return !lt;
            ALB_CC_GT:     return !lt && !f.z;
            ALB_CC_LE:     return lt || f.z;
            ALB_CC_LT:     return lt;
            ALB_CC_GTU:    return f.c && !f.z;
            ALB_CC_LEU:    return !f.c || f.z;
            ALB_CC_LTU:    return !f.c;
        endcase
    endfunction : cond_met

    alb_shift u_shift (
        .value_i  (op_a),
        .amount_i (shift_amt),
        .byte_i   (byte_m),
        .value_o  (shift_res)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_s   = s;
        accept   = instr_valid_i && s.ready;
        byte_m   = instr_i.byte_mode;
        wr_reg   = 1'b0;
        wr_file  = 1'b0;
        taken    = 1'b0;
        carry_in = 1'b0;
        wr_idx   = instr_i.wd;
        op_a     = s.file_op_accumulator[instr_i.wb];
        op_b     = s.file_op_accumulator[instr_i.ws];
        res      = 16'h0000;
        sum      = 17'h00000;
        nib      = 5'h00;
        clr_idx  = byte_m ? {1'b0, instr_i.bit_index_field[2:0]} : instr_i.bit_index_field;
        shift_amt = 4'h1;
        // Operand selection
        unique case (instr_i.form)
            ALB_FORM_FILE: begin
                op_a    = instr_i.file_rdata;
                op_b    = s.file_op_accumulator[`ALB_W0_IDX];
                wr_file = instr_i.dest_file;
                wr_reg  = !instr_i.dest_file;
                wr_idx  = `ALB_W0_IDX;
            end
            ALB_FORM_WIDE_IMMEDIATE: begin
                op_a   = byte_m ? {8'h00, instr_i.wide_immediate[7:0]} : {6'h00, instr_i.wide_immediate};
                op_b   = s.file_op_accumulator[instr_i.wd];
                wr_reg = 1'b1;
            end
            ALB_FORM_REG3: begin
                wr_reg = 1'b1;
            end
            ALB_FORM_SHORT_IMMEDIATE: begin
                op_b   = {11'h000, instr_i.short_immediate};
                wr_reg = 1'b1;
            end
        endcase
        if ((instr_i.op == ALB_OP_ASR1 || instr_i.op == ALB_OP_BIT_ZERO_OP)
            && instr_i.form != ALB_FORM_FILE) begin
            op_a = s.file_op_accumulator[instr_i.ws];
        end
        if (instr_i.op == ALB_OP_BIT_ZERO_OP) begin
            if (instr_i.form == ALB_FORM_FILE) begin
                wr_file = 1'b1;
                wr_reg  = 1'b0;
            end else begin
                wr_idx = instr_i.ws;
            end
        end
        dst_old = wr_file ? instr_i.file_rdata : s.file_op_accumulator[wr_idx];
        if (instr_i.op == ALB_OP_ASRW) begin
            shift_amt = s.file_op_accumulator[instr_i.ws][3:0];
        end else if (instr_i.op == ALB_OP_ASRK) begin
            shift_amt = instr_i.shift_immediate;
        end
        // Result
        unique case (instr_i.op)
            ALB_OP_ADD, ALB_OP_SUM_WITH_CARRY_OP: begin
                carry_in = (instr_i.op == ALB_OP_SUM_WITH_CARRY_OP) && s.flags.c;
                sum = {1'b0, lo_byte(op_a, byte_m)} + {1'b0, lo_byte(op_b, byte_m)}
                    + {16'h0000, carry_in};
                nib = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, carry_in};
                res = sum[15:0];
            end
            ALB_OP_AND:  res = op_a & op_b;
            ALB_OP_ASR1, ALB_OP_ASRW, ALB_OP_ASRK: res = shift_res;
            ALB_OP_BIT_ZERO_OP: res = op_a & ~(16'h0001 << clr_idx);
            ALB_OP_BRA: begin
                taken  = cond_met(instr_i.cond, s.flags);
                wr_reg = 1'b0;
                wr_file = 1'b0;
            end
            ALB_OP_BRAW: begin
                taken  = 1'b1;
                wr_reg = 1'b0;
                wr_file = 1'b0;
            end
            default: res = 16'h0000;
        endcase
        merged = byte_m ? {dst_old[15:8], res[7:0]} : res;

        // APB: zero wait, pready raised in the access phase
        is_file_op_accumulator = ((paddr_i & `ALB_FILE_OP_ACCUMULATOR_MASK) == `ALB_ADDR_FILE_OP_ACCUMULATOR_BASE) && paddr_i[1:0] == 2'b00;
        apb_wr  = psel_i && penable_i && s.pready && pwrite_i && !s.pslverr;
        next_s.pready = 1'b0;
        if (psel_i && !penable_i && !s.pready) begin
            next_s.pready  = 1'b1;
            next_s.pslverr = 1'b0;
            next_s.prdata  = 32'h0000_0000;
            if (paddr_i == `ALB_ADDR_CTRL) begin
                next_s.prdata[`ALB_CTRL_EN_BIT] = s.enable;
            end else if (paddr_i == `ALB_ADDR_STATUS) begin
                next_s.prdata[`ALB_ST_C]  = s.flags.c;
                next_s.prdata[`ALB_ST_DC] = s.flags.dc;
                next_s.prdata[`ALB_ST_N]  = s.flags.n;
                next_s.prdata[`ALB_ST_OV] = s.flags.ov;
                next_s.prdata[`ALB_ST_Z]  = s.flags.z;
            end else if (is_file_op_accumulator && !pwrite_i) begin
                next_s.prdata = {16'h0000, s.file_op_accumulator[paddr_i[5:2]]};
            end else begin
                next_s.pslverr = 1'b1;
            end
        end
        if (apb_wr && paddr_i == `ALB_ADDR_CTRL) begin
            next_s.enable = pwdata_i[`ALB_CTRL_EN_BIT];
        end
        // An instruction in flight owns the flags; a software write then loses
        if (apb_wr && paddr_i == `ALB_ADDR_STATUS && !accept) begin
            next_s.flags.c  = pwdata_i[`ALB_ST_C];
            next_s.flags.dc = pwdata_i[`ALB_ST_DC];
            next_s.flags.n  = pwdata_i[`ALB_ST_N];
            next_s.flags.ov = pwdata_i[`ALB_ST_OV];
            next_s.flags.z  = pwdata_i[`ALB_ST_Z];
        end

        // Execute
        next_s.mem_wr   = 1'b0;
        next_s.jump     = 1'b0;
        next_s.nop_slot = 1'b0;
        next_s.phase    = ALB_PH_EXEC;
        if (accept) begin
            if (wr_reg) begin
                next_s.file_op_accumulator[wr_idx] = merged;
            end
            if (wr_file) begin
                next_s.mem_wr   = 1'b1;
                next_s.mem_addr = instr_i.faddr;
                next_s.mem_data = merged;
            end
            unique case (instr_i.op)
                ALB_OP_ADD, ALB_OP_SUM_WITH_CARRY_OP: begin
                    next_s.flags.c  = byte_m ? sum[8] : sum[16];
                    next_s.flags.dc = nib[4];
                    next_s.flags.ov = (msb(op_a, byte_m) == msb(op_b, byte_m))
                                   && (msb(res, byte_m) != msb(op_a, byte_m));
                end
                ALB_OP_ASR1: begin
                    next_s.flags.c  = op_a[0];
                    next_s.flags.ov = 1'b0;
                end
                default: next_s.flags.c = next_s.flags.c;
            endcase
            if (instr_i.op inside {ALB_OP_ADD, ALB_OP_SUM_WITH_CARRY_OP, ALB_OP_AND, ALB_OP_ASR1,
                                   ALB_OP_ASRW, ALB_OP_ASRK}) begin
                next_s.flags.n = msb(res, byte_m);
                next_s.flags.z = is_zero(res, byte_m);
            end
            if (taken) begin
                next_s.jump     = 1'b1;
                next_s.jump_abs = (instr_i.op == ALB_OP_BRAW);
                next_s.jump_val = (instr_i.op == ALB_OP_BRAW) ? s.file_op_accumulator[instr_i.ws]
                                                               : instr_i.offset;
                next_s.nop_slot = 1'b1;
                next_s.phase    = ALB_PH_FLUSH;
            end
        end
        next_s.ready = next_s.enable && next_s.phase == ALB_PH_EXEC;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s        <= '0;
            s.enable <= `ALB_CTRL_EN_RST;
        end else begin
            s <= next_s;
        end
    end

    assign instr_ready_o = s.ready;
    assign nop_slot_o    = s.nop_slot;
    assign jump_o        = s.jump;
    assign jump_abs_o    = s.jump_abs;
    assign jump_val_o    = s.jump_val;
    assign mem_wr_o      = s.mem_wr;
    assign mem_addr_o    = s.mem_addr;
    assign mem_data_o    = s.mem_data;
    assign flags_o       = s.flags;
    assign prdata_o      = s.prdata;
    assign pready_o      = s.pready;
    assign pslverr_o     = s.pslverr;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    logic acc_br;
    assign acc_br = accept && instr_i.op inside {ALB_OP_BRA, ALB_OP_BRAW};

    sequence seq_taken;
        acc_br && taken && next_s.enable;
    endsequence
    sequence seq_flush_then_run;
        (!instr_ready_o && nop_slot_o && jump_o) ##1 instr_ready_o;
    endsequence

    chk_taken_two_cycle: assert property (seq_taken |=> seq_flush_then_run)
        else $error("taken branch did not spend exactly one dead cycle");
    chk_untaken_one_cycle: assert property (acc_br && !taken && next_s.enable
        |=> instr_ready_o && !jump_o && !nop_slot_o)
        else $error("untaken branch stalled");
    chk_nop_with_jump: assert property (nop_slot_o |-> jump_o && !instr_ready_o)
        else $error("no-operation slot without jump");
    chk_branch_flags_kept: assert property (acc_br |=> $stable(flags_o))
        else $error("branch changed status");
    chk_and_keeps_cv: assert property (accept && instr_i.op == ALB_OP_AND
        |=> $stable(flags_o.c) && $stable(flags_o.ov) && $stable(flags_o.dc))
        else $error("and changed carry or overflow");
    chk_shiftk_keeps_c: assert property (accept && instr_i.op == ALB_OP_ASRK
        |=> $stable(flags_o.c) && $stable(flags_o.ov))
        else $error("literal shift changed carry");
    chk_bit_zero_op_clears_bit: assert property (accept && instr_i.op == ALB_OP_BIT_ZERO_OP
        && instr_i.form != ALB_FORM_FILE && !instr_i.byte_mode
        |=> s.file_op_accumulator[$past(instr_i.ws)][$past(instr_i.bit_index_field)] == 1'b0 && $stable(flags_o))
        else $error("bit clear failed");
    chk_file_to_acc: assert property (accept && wr_reg && instr_i.form == ALB_FORM_FILE
        |=> s.file_op_accumulator[0] == $past(merged) && !mem_wr_o)
        else $error("accumulator not written");
    chk_file_write: assert property (accept && wr_file
        |=> mem_wr_o && mem_addr_o == $past(instr_i.faddr)
            && mem_data_o == $past(merged))
        else $error("file write missing");
    chk_byte_upper_kept: assert property (accept && wr_reg && instr_i.byte_mode
        |=> ((s.file_op_accumulator[$past(wr_idx)] ^ $past(dst_old)) & 16'hFF00) == 16'h0000)
        else $error("byte op touched upper byte");
endmodule : alb_core
`default_nettype wire

/* dv/alb_feed.sv */
// Decoder and data memory model facing the execution datapath
`default_nettype none
module alb_feed import alb_pkg::*; (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          sys_rst_i,
    // Instruction handshake
    input  wire logic          instr_ready_i,
    output logic               instr_valid_o,
    output alb_instr_type      instr_o,
    // File write-back
    input  wire logic          mem_wr_i,
    input  wire logic [12:0]   mem_addr_i,
    input  wire logic [15:0]   mem_data_i
);
    timeunit 1ns;
    timeprecision 1ps;
    alb_instr_type q [$];
    logic [15:0]   fmem [0:8191];
    int unsigned   acc_count;
    initial begin : fill
        foreach (fmem[i]) begin
            fmem[i] = 16'h0000;
        end
    end : fill
    always @(posedge clk_i or posedge sys_rst_i) begin : feed
        alb_instr_type nxt;
        if (sys_rst_i) begin
            instr_valid_o <= 1'h0;
            instr_o       <= '0;
            acc_count     <= 0;
        end else begin
            if (mem_wr_i) begin
                fmem[mem_addr_i] <= mem_data_i;
            end
            if (!instr_valid_o || instr_ready_i) begin
                if (instr_valid_o) begin
                    acc_count <= acc_count + 1;
                end
                if (q.size() > 0) begin
                    nxt = q.pop_front();
                    nxt.file_rdata = fmem[nxt.faddr];
                    instr_o       <= nxt;
                    instr_valid_o <= 1'h1;
                end else begin
                    // Idle fields toggle so a stale word never looks usable
                    instr_o       <= ~instr_o;
                    instr_valid_o <= 1'h0;
                end
            end
        end
    end : feed
endmodule : alb_feed
`default_nettype wire

/* dv/alb_core_tb_top.sv */
// Self-checking bench of the execution datapath with its decoder model
`default_nettype none
`include "alb_map.svh"
module alb_core_tb_top import alb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Case tables
    // ****************************************
    typedef struct packed {
        alb_op_type   op;
        alb_form_type form;
        logic         bm;
        logic [12:0]  fa;
        logic [11:0]  regs;
        logic [9:0]   lit;
        logic [15:0]  ev;
        logic [4:0]   ef;
    } alb_row_type;
    typedef struct packed {
        alb_cond_type cc;
        logic [4:0]   st;
        logic         tk;
    } alb_br_type;
    localparam int CYCLE_LIMIT = 5000;
    // Register nibbles are base, source, destination; flags are c, dc, n, ov, z
    alb_row_type rows [14] = '{
        '{ALB_OP_ADD, ALB_FORM_WIDE_IMMEDIATE, 1'h0, 13'h0000, 12'h111, 10'h3FF, 16'h03FF, 5'h00},
        '{ALB_OP_ADD, ALB_FORM_REG3, 1'h0, 13'h0000, 12'h112, 10'h000, 16'h07FE, 5'h08},
        '{ALB_OP_ADD, ALB_FORM_SHORT_IMMEDIATE, 1'h0, 13'h0000, 12'h223, 10'h01F, 16'h081D, 5'h08},
        '{ALB_OP_ASRK, ALB_FORM_REG3, 1'h0, 13'h0000, 12'h334, 10'h004, 16'h0081, 5'h08},
        '{ALB_OP_ADD, ALB_FORM_FILE, 1'h0, 13'h1FFF, 12'h550, 10'h000, 16'h8001, 5'h04},
        '{ALB_OP_ASR1, ALB_FORM_REG3, 1'h0, 13'h0000, 12'h008, 10'h000, 16'hC000, 5'h14},
        '{ALB_OP_ASRK, ALB_FORM_REG3, 1'h0, 13'h0000, 12'h009, 10'h00F, 16'hFFFF, 5'h14},
        '{ALB_OP_ASRW, ALB_FORM_REG3, 1'h0, 13'h0000, 12'h02A, 10'h000, 16'hFFFE, 5'h14},
        '{ALB_OP_ADD, ALB_FORM_FILE, 1'h0, 13'h1FFF, 12'h550, 10'h000, 16'h0002, 5'h12},
        '{ALB_OP_SUM_WITH_CARRY_OP, ALB_FORM_FILE, 1'h0, 13'h0010, 12'h550, 10'h000, 16'h0002, 5'h18},
        '{ALB_OP_AND, ALB_FORM_REG3, 1'h0, 13'h0000, 12'h126, 10'h000, 16'h03FE, 5'h18},
        '{ALB_OP_AND, ALB_FORM_SHORT_IMMEDIATE, 1'h0, 13'h0000, 12'h117, 10'h000, 16'h0000, 5'h19},
        '{ALB_OP_ADD, ALB_FORM_WIDE_IMMEDIATE, 1'h1, 13'h0000, 12'h111, 10'h3FF, 16'h03FE, 5'h1C},
        '{ALB_OP_BIT_ZERO_OP, ALB_FORM_REG3, 1'h0, 13'h0000, 12'h666, 10'h001, 16'h03FC, 5'h1C}};
    // Status image is bit0 c up to bit4 z
    alb_br_type brs [13] = '{
        '{ALB_CC_C, 5'h01, 1'h1}, '{ALB_CC_C, 5'h00, 1'h0}, '{ALB_CC_GE, 5'h0C, 1'h1},
        '{ALB_CC_GE, 5'h04, 1'h0}, '{ALB_CC_GT, 5'h00, 1'h1}, '{ALB_CC_GT, 5'h10, 1'h0},
        '{ALB_CC_LE, 5'h10, 1'h1}, '{ALB_CC_LE, 5'h00, 1'h0}, '{ALB_CC_GTU, 5'h01, 1'h1},
        '{ALB_CC_GTU, 5'h11, 1'h0}, '{ALB_CC_LEU, 5'h00, 1'h1}, '{ALB_CC_LEU, 5'h01, 1'h0},
        '{ALB_CC_ALWAYS, 5'h00, 1'h1}};
    logic          clk = 1'h0;
    logic          sys_rst = 1'h1;
    logic          psel = 1'h0;
    logic          penable = 1'h0;
    logic          pwrite = 1'h0;
    logic [11:0]   paddr = 12'h000;
    logic [31:0]   pwdata = 32'h0;
    logic          instr_valid, instr_ready, nop_slot, jump, jump_abs, mem_wr;
    logic          pready, pslverr, err;
    alb_instr_type instr;
    alb_instr_type t;
    alb_flags_type flags;
    logic [15:0]   jump_val, mem_data;
    logic [12:0]   mem_addr;
    logic [31:0]   prdata, rd;
    int            err_total = 0;
    int            check_count = 0;
    int            cycles = 0;
    // ****************************************
    // Design and decoder model
    // ****************************************
    alb_core u_alb_core (.clk_i(clk), .sys_rst_i(sys_rst), .instr_valid_i(instr_valid),
        .instr_i(instr), .instr_ready_o(instr_ready), .nop_slot_o(nop_slot), .jump_o(jump),
        .jump_abs_o(jump_abs), .jump_val_o(jump_val), .mem_wr_o(mem_wr),
        .mem_addr_o(mem_addr), .mem_data_o(mem_data), .flags_o(flags), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
    alb_feed u_alb_feed (.clk_i(clk), .sys_rst_i(sys_rst), .instr_ready_i(instr_ready),
        .instr_valid_o(instr_valid), .instr_o(instr), .mem_wr_i(mem_wr),
        .mem_addr_i(mem_addr), .mem_data_i(mem_data));
    always #5 clk = ~clk;
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic rdw(input logic [3:0] i, input logic [15:0] e);
        apb(1'h0, `ALB_ADDR_FILE_OP_ACCUMULATOR_BASE + {6'h00, i, 2'h0}, 32'h0);
        chk(rd, {16'h0, e}, "working register");
    endtask : rdw
    task automatic issue(input alb_instr_type x);
        int unsigned k;
        k = u_alb_feed.acc_count + u_alb_feed.q.size() + 1;
        u_alb_feed.q.push_back(x);
        while (u_alb_feed.acc_count < k) @(negedge clk);
    endtask : issue
    function automatic alb_instr_type mk(input alb_row_type r);
        alb_instr_type x;
        x = '0;
        x.op = r.op;
        x.form = r.form;
        x.byte_mode = r.bm;
        x.faddr = r.fa;
        {x.wb, x.ws, x.wd} = r.regs;
        x.wide_immediate = r.lit;
        x.short_immediate = r.lit[4:0];
        x.shift_immediate = r.lit[3:0];
        x.bit_index_field = r.lit[3:0];
        return x;
    endfunction : mk
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == CYCLE_LIMIT) begin
            err_total++;
            end_sim();
        end
    end
    // ****************************************
    // Sequence
    // ****************************************
    initial begin : main
        repeat (4) @(posedge clk);
        sys_rst <= 1'h0;
        u_alb_feed.fmem[13'h1FFF] = 16'h8001;
        u_alb_feed.fmem[13'h0010] = 16'hFFFF;
        apb(1'h0, `ALB_ADDR_CTRL, 32'h0);
        chk(rd, 32'h1, "enable after reset");
        apb(1'h0, `ALB_ADDR_STATUS, 32'h0);
        chk(rd, 32'h0, "status after reset");
        rdw(4'hF, 16'h0000);
        foreach (rows[i]) begin
            issue(mk(rows[i]));
            chk({27'h0, flags}, {27'h0, rows[i].ef}, "flags");
            rdw(rows[i].regs[3:0], rows[i].ev);
        end
        // Accumulator plus file, result to the file location
        t = '0;
        t.op = ALB_OP_ADD;
        t.dest_file = 1'h1;
        t.faddr = 13'h0010;
        issue(t);
        chk({31'h0, mem_wr}, 32'h1, "file write");
        chk({19'h0, mem_addr}, 32'h0010, "file address");
        chk({16'h0, mem_data}, 32'h0001, "file data");
        chk({27'h0, flags}, 32'h18, "file add flags");
        rdw(4'h0, 16'h0002);
        apb(1'h1, 12'h044, 32'h1234);
        chk({31'h0, err}, 32'h1, "write to read-only window");
        apb(1'h0, 12'h008, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped read");
        foreach (brs[i]) begin
            apb(1'h1, `ALB_ADDR_STATUS, {27'h0, brs[i].st});
            t = '0;
            t.op = ALB_OP_BRA;
            t.cond = brs[i].cc;
            t.offset = 16'h0100 + 16'(i);
            issue(t);
            chk({31'h0, jump}, {31'h0, brs[i].tk}, "branch taken");
            chk({31'h0, nop_slot}, {31'h0, brs[i].tk}, "no-op slot");
            chk({31'h0, instr_ready}, {31'h0, !brs[i].tk}, "dead cycle");
            chk({27'h0, flags}, {27'h0, brs[i].st[0], brs[i].st[1], brs[i].st[2],
                brs[i].st[3], brs[i].st[4]}, "branch flags");
            if (brs[i].tk) begin
                chk({15'h0, jump_abs, jump_val}, {16'h0, t.offset}, "branch offset");
            end
            @(negedge clk);
            chk({30'h0, instr_ready, jump}, 32'h2, "after branch");
        end
        // Taken branch then an add queued behind it: the add must survive
        t = '0;
        t.op = ALB_OP_BRA;
        t.offset = 16'h0040;
        u_alb_feed.q.push_back(t);
        issue(mk('{ALB_OP_ADD, ALB_FORM_WIDE_IMMEDIATE, 1'h0, 13'h0000, 12'h555, 10'h001,
            16'h0001, 5'h00}));
        chk({30'h0, nop_slot, jump}, 32'h0, "add after dead cycle");
        rdw(4'h5, 16'h0001);
        // Computed branch jumps to the value held in the source register
        t = '0;
        t.op = ALB_OP_BRAW;
        t.ws = 4'h6;
        issue(t);
        chk({15'h0, jump_abs, jump_val}, {15'h0, 1'h1, 16'h03FC}, "computed branch");
        chk({31'h0, nop_slot}, 32'h1, "computed no-op slot");
        end_sim();
    end : main
endmodule : alb_core_tb_top
`default_nettype wire
